/* inc/wdt_consts.svh */
// constants for the watchdog and periodic tick block
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define WDT_CLK_HZ 40000000
`define WDT_MIN_PERIOD_US 15625
`define WDT_CNT_STEPS 256
`define WDT_BASE_CYCLES ((`WDT_CLK_HZ / 1000000 * `WDT_MIN_PERIOD_US) / `WDT_CNT_STEPS)
`define WDT_TICK_PRE 2'h3
`define WDT_CNT_MAX 8'hFF
`define WDT_CNT_RST 8'h00
`define WDT_KEY_OK 8'hA5
`define WDT_RATE_LSB 0
`define WDT_RATE_MSB 2
`define WDT_RATE_RST 3'h0
`define WDT_CHECK_LSB 3
`define WDT_CHECK_MSB 5
`define WDT_CHECK_OK 3'h5
`define WDT_PRE_ALL 6'h3F
`define WDT_TICK_DIV_RST 12'h000
`endif

/* inc/wdt_pkg.sv */
// types shared by the watchdog and periodic tick block
package wdt_pkg;
  // one register write: strobe plus data byte
  typedef struct packed {
    logic strobe;
    logic [7:0] data;
  } wdt_wr_type;
  // periodic tick configuration write
  typedef struct packed {
    logic strobe;
    logic irq_en;
    logic [11:0] div;
  } wdt_tick_cfg_type;
endpackage

/* design/wdt_div.sv */
// enable-gated rate divider producing one-cycle pulses
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_div #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // rate control
  input wire logic en_in,
  input wire logic [WIDTH-1:0] limit_in,
  // rate output
  output logic pulse_out
);
  logic [WIDTH-1:0] cnt_q; // position within period
  logic [WIDTH-1:0] cnt_d;

  // next count, wrap at limit
  always_comb begin
    cnt_d = cnt_q;
    pulse_out = 1'b0;
    if (en_in) begin
      if (cnt_q >= limit_in) begin
        cnt_d = '0;
        pulse_out = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // register count
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

/* design/wdt_top.sv */
// watchdog timer with periodic tick generator
//
// Overview of operation
// R1: seven watchdog overflow periods, 15.63 ms to 1 s
// R2: counter overflow requests a system reset
// R3: correct service key clears watchdog counter
// R4: wrong service key requests immediate reset
// R5: reset origin flag marks watchdog-caused resets
// R6: control writes need check bits 101
// R7: watchdog runs from reset release, no enable
// R8: tick rate 1 to 4096 per second
// R9: tick status pollable without interrupt enabled
// R10: three watchdog, two tick control registers
// R11: tick flag sticky; irq only when enabled
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_top
  import wdt_pkg::*;
#(
  parameter int BASE_CYCLES = `WDT_BASE_CYCLES,
  parameter logic [7:0] SERVICE_KEY = `WDT_KEY_OK
) (
  // clock and resets
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic por_in,
  // watchdog register writes
  input wire wdt_wr_type key_wr_in, // R10
  input wire wdt_wr_type ctl_wr_in,
  input wire logic origin_clr_in,
  // tick register writes
  input wire wdt_tick_cfg_type tick_cfg_in, // R10
  input wire logic tick_clr_in,
  // watchdog status
  output logic sys_rst_req_out,
  output logic reset_origin_flag_out,
  output logic [7:0] wd_count_out,
  output logic [2:0] wd_rate_out,
  // tick status
  output logic tick_flag_out,
  output logic tick_irq_out
);
  ////////////////////////////////////////////////////////////////////
  // rate dividers
  logic base_en; // base step, 256 per shortest period
  logic tick_base_en; // 4096 Hz tick base
  logic tick_pulse; // one per programmed tick interval
  logic [11:0] tick_div_q; // tick interval minus one, in 4096 Hz tick base periods
  logic [11:0] tick_div_d;
  logic tick_ie_q; // tick interrupt enable
  logic tick_ie_d;

  // clock to watchdog base rate
  wdt_div #(.WIDTH(12)) u_base_div (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .en_in(1'b1),
    .limit_in(12'(BASE_CYCLES - 1)),
    .pulse_out(base_en)
  );

  // watchdog base down to tick base
  wdt_div #(.WIDTH(2)) u_tick_base_div (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .en_in(base_en),
    .limit_in(`WDT_TICK_PRE),
    .pulse_out(tick_base_en)
  );

  // programmable tick interval
  wdt_div #(.WIDTH(12)) u_tick_div (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .en_in(tick_base_en),
    .limit_in(tick_div_q), // R8
    .pulse_out(tick_pulse)
  );

  ////////////////////////////////////////////////////////////////////
  // watchdog control and counter
  logic [2:0] rate_q; // overflow rate select
  logic [2:0] rate_d;
  logic [5:0] pre_q; // base step prescaler
  logic [5:0] pre_d;
  logic [7:0] cnt_q; // watchdog counter
  logic [7:0] cnt_d;
  logic rst_req_q; // reset request pulse
  logic rst_req_d;
  logic [2:0] shift; // log2 of prescale
  logic [5:0] pre_mask; // prescaler bits that must be set
  logic wd_step; // counter advance
  logic key_ok; // service key write accepted
  logic key_bad; // wrong key written
  logic ctl_bad; // check bits wrong
  logic overflow; // counter at end

  // decode writes, rate and overflow
  always_comb begin
    key_ok = key_wr_in.strobe && (key_wr_in.data == SERVICE_KEY); // R3
    key_bad = key_wr_in.strobe && (key_wr_in.data != SERVICE_KEY); // R4
    ctl_bad = ctl_wr_in.strobe &&
      (ctl_wr_in.data[`WDT_CHECK_MSB:`WDT_CHECK_LSB] != `WDT_CHECK_OK); // R6
    // codes 0 and 1 both shortest; 7 gives 64 times slower
    shift = (rate_q == 3'h0) ? 3'h0 : rate_q - 3'h1; // R1
    pre_mask = ~(`WDT_PRE_ALL << shift);
    wd_step = base_en && ((pre_q & pre_mask) == pre_mask); // R7
    overflow = wd_step && (cnt_q == `WDT_CNT_MAX);
  end

  // next watchdog state
  always_comb begin
    rate_d = rate_q;
    pre_d = pre_q;
    cnt_d = cnt_q;
    rst_req_d = key_bad || ctl_bad || overflow; // R2 R4 R6
    // rate taken only from writes with good check bits
    if (ctl_wr_in.strobe && !ctl_bad) begin
      rate_d = ctl_wr_in.data[`WDT_RATE_MSB:`WDT_RATE_LSB]; // R1
    end
    if (base_en) begin
      pre_d = pre_q + 6'h01;
    end
    // service clears, else count; wrap after overflow
    if (key_ok) begin
      cnt_d = `WDT_CNT_RST; // R3
      pre_d = '0;
    end else if (overflow) begin
      cnt_d = `WDT_CNT_RST; // R2
    end else if (wd_step) begin
      cnt_d = cnt_q + 8'h01; // R7
    end
  end

  // register watchdog state
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rate_q <= `WDT_RATE_RST;
      pre_q <= '0;
      cnt_q <= `WDT_CNT_RST;
      rst_req_q <= 1'b0;
    end else begin
      rate_q <= rate_d;
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      rst_req_q <= rst_req_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // reset origin flag, survives system reset
  logic origin_q; // last reset came from watchdog
  logic origin_d;

  // set wins over software clear
  always_comb begin
    origin_d = origin_q;
    if (origin_clr_in) begin
      origin_d = 1'b0;
    end
    if (rst_req_q) begin
      origin_d = 1'b1; // R5
    end
  end

  // cleared by power-on reset or software clear, not by rst_in
  always_ff @(posedge ref_clk_in) begin
    if (por_in) begin
      origin_q <= 1'b0;
    end else begin
      origin_q <= origin_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // tick configuration and status
  logic tick_flag_q; // sticky tick status
  logic tick_flag_d;
  logic tick_irq_q; // gated interrupt request
  logic tick_irq_d;

  // next tick state, set wins over clear
  always_comb begin
    tick_div_d = tick_div_q;
    tick_ie_d = tick_ie_q;
    tick_flag_d = tick_flag_q;
    if (tick_cfg_in.strobe) begin
      tick_div_d = tick_cfg_in.div; // R8
      tick_ie_d = tick_cfg_in.irq_en;
    end
    if (tick_clr_in) begin
      tick_flag_d = 1'b0;
    end
    if (tick_pulse) begin
      tick_flag_d = 1'b1; // R9 R11
    end
    tick_irq_d = tick_flag_d && tick_ie_d; // R11
  end

  // register tick state
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tick_div_q <= `WDT_TICK_DIV_RST;
      tick_ie_q <= 1'b0;
      tick_flag_q <= 1'b0;
      tick_irq_q <= 1'b0;
    end else begin
      tick_div_q <= tick_div_d;
      tick_ie_q <= tick_ie_d;
      tick_flag_q <= tick_flag_d;
      tick_irq_q <= tick_irq_d;
    end
  end

  // outputs, all from flip-flops
  assign sys_rst_req_out = rst_req_q;
  assign reset_origin_flag_out = origin_q;
  assign wd_count_out = cnt_q;
  assign wd_rate_out = rate_q;
  assign tick_flag_out = tick_flag_q;
  assign tick_irq_out = tick_irq_q;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_bad_key_reset: assert property (key_bad |=> sys_rst_req_out) // R4
    else $error("wrong key did not request reset");
  a_good_key_clear: assert property (key_ok |=> wd_count_out == `WDT_CNT_RST) // R3
    else $error("service key did not clear counter");
  a_check_bits_reset: assert property (ctl_bad |=> sys_rst_req_out && $stable(wd_rate_out)) // R6
    else $error("bad check bits not handled");
  a_overflow_reset: assert property (wd_step && !key_ok && wd_count_out == `WDT_CNT_MAX
    |=> sys_rst_req_out && wd_count_out == `WDT_CNT_RST) // R2
    else $error("overflow did not request reset");
  a_no_spurious_reset: assert property (!key_bad && !ctl_bad && !overflow |=> !sys_rst_req_out) // R2
    else $error("reset requested without cause");
  a_count_advance: assert property (wd_step && !key_ok && wd_count_out != `WDT_CNT_MAX
    |=> wd_count_out == $past(wd_count_out) + 8'h01) // R7
    else $error("counter did not advance");
  a_rate_load: assert property (ctl_wr_in.strobe && !ctl_bad
    |=> wd_rate_out == $past(ctl_wr_in.data[`WDT_RATE_MSB:`WDT_RATE_LSB])) // R1
    else $error("rate not loaded");
  a_origin_mark: assert property (sys_rst_req_out |=> reset_origin_flag_out [*2]) // R5
    else $error("origin flag not set");
  a_tick_flag_set: assert property (tick_pulse |=> tick_flag_out) // R9
    else $error("tick flag not set");
  a_tick_irq_gate: assert property (tick_pulse && tick_ie_q && !tick_cfg_in.strobe
    |=> tick_irq_out ##0 tick_flag_out) // R11
    else $error("tick irq not raised");
  a_tick_irq_mask: assert property (!tick_ie_q |=> !tick_irq_out || $past(tick_cfg_in.strobe)) // R11
    else $error("tick irq while disabled");
endmodule

/* dv/test_wdt_top.sv */
// self-checking bench for the watchdog and periodic tick block
`timescale 1ns/1ps
`include "wdt_consts.svh"
module test_wdt_top import wdt_pkg::*;;
  localparam int BASE = 4; // shortened base step
  // design inputs
  logic ref_clk_in, rst_in, por_in, origin_clr_in, tick_clr_in;
  wdt_wr_type key_wr_in, ctl_wr_in;
  wdt_tick_cfg_type tick_cfg_in;
  // design outputs
  logic sys_rst_req_out, reset_origin_flag_out, tick_flag_out, tick_irq_out;
  logic [7:0] wd_count_out;
  logic [2:0] wd_rate_out;
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 32'h8a0e;
  int n;
  logic [7:0] d;
  logic [11:0] dv;
  ////////////////////////////////////////////////////////////////
  wdt_top #(.BASE_CYCLES(BASE)) DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .por_in(por_in),
    .key_wr_in(key_wr_in), .ctl_wr_in(ctl_wr_in), .origin_clr_in(origin_clr_in),
    .tick_cfg_in(tick_cfg_in), .tick_clr_in(tick_clr_in), .sys_rst_req_out(sys_rst_req_out),
    .reset_origin_flag_out(reset_origin_flag_out), .wd_count_out(wd_count_out),
    .wd_rate_out(wd_rate_out), .tick_flag_out(tick_flag_out), .tick_irq_out(tick_irq_out));
  // 40 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  ////////////////////////////////////////////////////////////////
  // compare and count
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // step k edges, sample 1 ns later
  task cyc(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask
  // reset held 12 cycles
  task do_reset;
    @(posedge ref_clk_in) rst_in <= 1'b1;
    repeat (12) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    #1;
  endtask
  // one write: 0 key, 1 control
  task wr(input bit ctl, input logic [7:0] v);
    @(posedge ref_clk_in);
    if (ctl) ctl_wr_in <= '{1'b1, v};
    else key_wr_in <= '{1'b1, v};
    @(posedge ref_clk_in);
    ctl_wr_in.strobe <= 1'b0;
    key_wr_in.strobe <= 1'b0;
    #1;
  endtask
  // one-cycle pulse on a clear input
  task pulse_clr(input bit tk);
    @(posedge ref_clk_in);
    if (tk) tick_clr_in <= 1'b1;
    else origin_clr_in <= 1'b1;
    @(posedge ref_clk_in);
    tick_clr_in <= 1'b0;
    origin_clr_in <= 1'b0;
    #1;
  endtask
  // bounded wait for reset request or tick flag
  task wait_hi(input bit tk, output int k);
    k = 0;
    while ((tk ? tick_flag_out : sys_rst_req_out) !== 1'b1) begin
      if (k > 20000) begin
        n_mismatch++;
        close_out();
      end
      cyc(1);
      k++;
    end
  endtask
  // overflow time in clocks for a rate code
  function int ovf_cycles(input int r);
    return 256 * BASE * (1 << ((r < 2 ? 1 : r) - 1));
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    rst_in = 1'b1;
    por_in = 1'b1;
    origin_clr_in = 1'b0;
    tick_clr_in = 1'b0;
    key_wr_in = '0;
    ctl_wr_in = '0;
    tick_cfg_in = '0;
    do_reset();
    por_in <= 1'b0;
    chk({sys_rst_req_out, reset_origin_flag_out, wd_rate_out, tick_irq_out}, 16'h0000);
    cyc(BASE * 10);
    chk(wd_count_out >= 8'h08 && wd_count_out <= 8'h0B, 16'h0001);
    $display("reset and free run done");
    // every rate code with good check bits
    for (int r = 0; r < 8; r++) begin
      wr(1'b1, {2'h0, 3'h5, r[2:0]});
      chk(wd_rate_out, r[2:0]);
      chk(sys_rst_req_out, 16'h0000);
    end
    wr(1'b0, `WDT_KEY_OK);
    chk(wd_count_out, 16'h0000);
    chk(sys_rst_req_out, 16'h0000);
    $display("control and service done");
    // random wrong keys
    repeat (4) begin
      d = $random(seed);
      if (d == `WDT_KEY_OK) d = 8'h5A;
      wr(1'b0, d);
      chk(sys_rst_req_out, 16'h0001);
      cyc(1);
      chk(reset_origin_flag_out, 16'h0001);
      do_reset();
      chk(reset_origin_flag_out, 16'h0001);
      pulse_clr(1'b0);
      chk(reset_origin_flag_out, 16'h0000);
    end
    $display("wrong key done");
    // each bad check pattern keeps the old rate
    for (int c = 0; c < 8; c++) begin
      if (c == 5) continue;
      wr(1'b1, {2'h0, 3'h5, 3'h3});
      wr(1'b1, {2'h0, c[2:0], 3'h6});
      chk(sys_rst_req_out, 16'h0001);
      chk(wd_rate_out, 16'h0003);
      do_reset();
    end
    $display("check bits done");
    // overflow after starving the watchdog
    for (int r = 0; r < 4; r++) begin
      wr(1'b1, {2'h0, 3'h5, r[2:0]});
      wr(1'b0, `WDT_KEY_OK);
      wait_hi(1'b0, n);
      chk(n > ovf_cycles(r) - 8 && n < ovf_cycles(r) + 8, 16'h0001);
      do_reset();
    end
    $display("overflow done");
    // tick polled, then with interrupt
    for (int q = 0; q < 2; q++) begin
      dv = q ? 12'h000 : $random(seed) & 12'h007;
      @(posedge ref_clk_in) tick_cfg_in <= '{1'b1, q[0], dv};
      @(posedge ref_clk_in) tick_cfg_in.strobe <= 1'b0;
      #1;
      repeat (3) begin
        wait_hi(1'b1, n);
        chk(tick_irq_out, q[0]);
        cyc(1);
        chk(tick_flag_out, 16'h0001);
        pulse_clr(1'b1);
        chk({tick_flag_out, tick_irq_out}, 16'h0000);
      end
      wait_hi(1'b1, n);
      chk(n + 3, (dv + 1) * 4 * BASE);
    end
    $display("tick done");
    close_out();
  end
endmodule
